// >>> tdl_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tdl_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // Fill side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady,
   // Fill level
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("tdl_fifo: DEPTH must be a power of two");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic doWr, doRd;
   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != '0);
   assign outData = mem[rdPtr_reg[AW-1:0]];
   assign count = wrPtr_reg - rdPtr_reg;
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   always_comb begin
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      if (flush) begin
         rdPtr_next = wrPtr_reg;
      end else begin
         if (doWr) wrPtr_next = wrPtr_reg + 1'b1;
         if (doRd) rdPtr_next = rdPtr_reg + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
      end
   end
   always_ff @(posedge clk) begin
      if (doWr && !flush) mem[wrPtr_reg[AW-1:0]] <= inData;
   end
endmodule : tdl_fifo

// >>> tdl_pkg.sv
// Constants and types shared by the transmit data link block
// Overview of operation
// - Link bits in C-bits, N-bit, or one byte
// - Disabled link sends all ones
// - Flags sent when idle and between messages
// - Zero inserted after five ones in messages
// - Abort is sixteen consecutive ones
// - Optional sixteen-bit check sequence appended
// - Dedicated 128-byte transmit message FIFO
// - Two write addresses: ordinary and end-of-message
// - Near-empty flag set at or below threshold
// - Underrun flag on empty non-final request
// - Message-sent flag after closing flag
// - Each interrupt individually enabled
// - Empty and full status bits
// - Reset disables link, per-mode enable field
// - Link disable clears FIFO, sends ones
// - Two flags before message, flags while empty
// - Channel enable clears FIFO, keeps underrun and message-sent flags
// - Channel disable keeps settings, status, FIFO
// - End: check sequence, flag, message sent, second flag
// - Underrun: abort, flags, writes rejected
// - Writes to full FIFO silently dropped
package tdl_pkg;
   localparam int TDL_FIFO_DEPTH = 128;
   localparam int TDL_THR_MAX = 126;
   localparam logic [1:0] TDL_FMT_DS3 = 2'h0;
   localparam logic [1:0] TDL_FMT_G751 = 2'h1;
   localparam logic [1:0] TDL_FMT_G832 = 2'h2;
   localparam logic [7:0] TDL_FLAG = 8'h7e;
   localparam logic [15:0] TDL_CRC_POLY = 16'h8408;
   localparam logic [15:0] TDL_CRC_INIT = 16'hffff;
   localparam int TDL_ABORT_ONES = 16;
   localparam int TDL_LEAD_FLAGS = 2;
   localparam logic [2:0] TDL_MODE_RST = 3'h0;
   typedef enum logic [2:0] {
      TDL_IDLE = 3'b000,
      TDL_DATA = 3'b001,
      TDL_CRC = 3'b010,
      TDL_ABORT = 3'b011,
      TDL_FLAGS = 3'b100
   } tdl_state_t;
endpackage : tdl_pkg

// >>> tdl_slot_mdl.sv
// Slot pacer and HDLC receiver standing in for the frame inserter
`timescale 1ns/1ps
module tdl_slot_mdl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Idle cycles between slots
   input wire logic [3:0] gap,
   // Overhead slot
   output logic slotStrobe,
   input wire logic slotBit,
   // Receive counts
   output int frames,
   output int flags,
   output int aborts,
   output int zeros
);
   logic [7:0] rxq[$];
   logic [7:0] cur[$];
   logic [7:0] sh;
   logic pend = 1'b0;
   logic bad = 1'b0;
   int ones, nb, tick;
   task automatic take(input logic b);
      sh = {b, sh[7:1]};
      nb++;
      if (nb % 8 == 0) cur.push_back(sh);
   endtask : take
   always @(posedge clk) begin
      pend <= slotStrobe && !rst;
      slotStrobe <= !rst && tick == 0;
      tick = (tick >= gap) ? 0 : tick + 1;
      // Bit is read a cycle after its strobe
      if (pend) begin
         if (slotBit !== 1'b1) zeros++;
         if (slotBit === 1'b1) begin
            ones++;
            if (ones == 7) aborts++;
            if (ones == 7) bad = 1'b1;
            take(1'b1);
         end else if (ones == 6) begin
            flags++;
            if (!bad && cur.size() > 0) frames++;
            if (!bad) rxq = {rxq, cur};
            cur = {};
            nb = 0;
            bad = 1'b0;
            ones = 0;
         end else begin
            // Stuffed zero is dropped
            if (ones != 5) take(1'b0);
            ones = 0;
         end
      end
   end
endmodule : tdl_slot_mdl

// >>> tdl_tx_link.sv
// Transmit terminal data link: message FIFO plus HDLC formatter
`timescale 1ns/1ps
module tdl_tx_link
   import tdl_pkg::*;
#(
   parameter int DEPTH = TDL_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host byte writes
   input wire logic msgWrite,
   input wire logic msgEndAddr,
   input wire logic [7:0] message_byte_port,
   input wire logic statusRead,
   // Control
   input wire logic channelEnable,
   input wire logic [1:0] frameFormat,
   input wire logic [2:0] link_mode_select,
   input wire logic check_sequence_enable,
   input wire logic near_empty_irq_enable,
   input wire logic underrun_irq_enable,
   input wire logic message_sent_irq_enable,
   input wire logic [6:0] near_empty_threshold,
   // Overhead slot from frame inserter
   input wire logic slotStrobe,
   output logic slotBit,
   // Status
   output logic near_empty_flag,
   output logic fifo_empty_flag,
   output logic underrun_flag,
   output logic message_sent_flag,
   output logic fifo_full_flag,
   output logic linkIrq
);
   localparam int CW = $clog2(DEPTH);
   initial begin
      if (DEPTH != TDL_FIFO_DEPTH) begin
         $error("tdl_tx_link: DEPTH must be 128");
      end
   end
   logic linkOn, active, active_reg, linkOn_reg, flush;
   logic fifoInReady, fifoOutValid, fifoPop;
   logic [8:0] fifoOut;
   logic [CW:0] count;
   // One link bit per slot in the selected format
   assign linkOn = link_mode_select[frameFormat];
   assign active = linkOn && channelEnable;
   // Flush on link turn-off or channel turn-on with link enabled
   assign flush = (linkOn_reg && !linkOn) ||
      (!active_reg && active && linkOn_reg);

   logic ne_reg, ne_next, ur_reg, ur_next, ms_reg, ms_next;
   logic slot_reg, slot_next, irq_reg, irq_next;
   logic emp_reg, full_reg;
   logic urEvent, msEvent;
   logic acceptWr;
   assign acceptWr = msgWrite && !ur_reg;
   tdl_fifo #(.WIDTH(9), .DEPTH(DEPTH)) uFifo (
      .clk(clk),
      .rst(rst),
      .flush(flush),
      .inValid(acceptWr),
      .inData({msgEndAddr, message_byte_port}),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOut),
      .outReady(fifoPop),
      .count(count)
   );

   // Formatter state
   tdl_state_t st_reg, st_next;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] bc_reg, bc_next;
   logic [2:0] ones_reg, ones_next;
   logic [1:0] fl_reg, fl_next;
   logic [15:0] crc_reg, crc_next;
   logic eom_reg, eom_next, stuff;
   logic dataBit;
   logic [15:0] crcOut;
   assign crcOut = ~crc_reg;
   assign stuff = (st_reg == TDL_DATA || st_reg == TDL_CRC) &&
      ones_reg == 3'd5;
   assign fifoPop = active && slotStrobe && fifoOutValid && !stuff &&
      ((st_reg == TDL_DATA && bc_reg == 4'd7 && !eom_reg) ||
      (st_reg == TDL_FLAGS && bc_reg == 4'd7 && fl_reg == 2'd0));

   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      bc_next = bc_reg;
      ones_next = ones_reg;
      fl_next = fl_reg;
      crc_next = crc_reg;
      eom_next = eom_reg;
      urEvent = 1'b0;
      msEvent = 1'b0;
      dataBit = 1'b1;
      if (!active) begin
         st_next = TDL_IDLE;
      end else if (slotStrobe) begin
         case (st_reg)
            TDL_IDLE: begin
               dataBit = 1'b1;
               st_next = TDL_FLAGS;
               sh_next = TDL_FLAG;
               bc_next = 4'd0;
               fl_next = 2'(TDL_LEAD_FLAGS - 1);
            end
            TDL_DATA, TDL_CRC: begin
               if (stuff) begin
                  dataBit = 1'b0;
                  ones_next = 3'd0;
               end else begin
                  dataBit = sh_reg[0];
                  ones_next = dataBit ? ones_reg + 3'd1 : 3'd0;
                  sh_next = {1'b0, sh_reg[7:1]};
                  bc_next = bc_reg + 4'd1;
                  if (st_reg == TDL_DATA) begin
                     crc_next = {1'b0, crc_reg[15:1]} ^
                        ((crc_reg[0] ^ dataBit) ? TDL_CRC_POLY : 16'h0000);
                  end
                  if (bc_reg == 4'd7 && st_reg == TDL_DATA) begin
                     bc_next = 4'd0;
                     if (eom_reg) begin
                        if (check_sequence_enable) begin
                           // Last data bit must be in the check value
                           st_next = TDL_CRC;
                           sh_next = ~crc_next[7:0];
                           fl_next = 2'd0;
                        end else begin
                           st_next = TDL_FLAGS;
                           sh_next = TDL_FLAG;
                           fl_next = 2'd1;
                        end
                     end else if (fifoOutValid) begin
                        sh_next = fifoOut[7:0];
                        eom_next = fifoOut[8];
                     end else begin
                        urEvent = 1'b1;
                        st_next = TDL_ABORT;
                     end
                  end else if (bc_reg == 4'd7 && fl_reg == 2'd0) begin
                     // Flag count marks the second check byte
                     bc_next = 4'd0;
                     sh_next = crcOut[15:8];
                     fl_next = 2'd3;
                  end else if (bc_reg == 4'd7) begin
                     st_next = TDL_FLAGS;
                     sh_next = TDL_FLAG;
                     bc_next = 4'd0;
                     fl_next = 2'd1;
                  end
               end
            end
            TDL_ABORT: begin
               dataBit = 1'b1;
               bc_next = bc_reg + 4'd1;
               if (bc_reg == 4'(TDL_ABORT_ONES - 1)) begin
                  st_next = TDL_FLAGS;
                  sh_next = TDL_FLAG;
                  bc_next = 4'd0;
                  fl_next = 2'd1;
               end
            end
            default: begin
               dataBit = sh_reg[0];
               sh_next = {sh_reg[0], sh_reg[7:1]};
               bc_next = bc_reg + 4'd1;
               if (bc_reg == 4'd7) begin
                  bc_next = 4'd0;
                  if (fl_reg != 2'd0) begin
                     fl_next = fl_reg - 2'd1;
                     if (fl_reg == 2'd1 && eom_reg) msEvent = 1'b1;
                  end else if (fifoOutValid) begin
                     st_next = TDL_DATA;
                     sh_next = fifoOut[7:0];
                     eom_next = fifoOut[8];
                     ones_next = 3'd0;
                     crc_next = TDL_CRC_INIT;
                  end
                  if (fl_reg == 2'd1) eom_next = 1'b0;
               end
            end
         endcase
      end
   end

   // Flags: set wins over clear by status read
   always_comb begin
      ur_next = urEvent || (ur_reg && !statusRead);
      ms_next = msEvent || (ms_reg && !statusRead);
      ne_next = ne_reg;
      if (count <= (CW+1)'(near_empty_threshold)) ne_next = 1'b1;
      else ne_next = 1'b0;
      slot_next = (active && slotStrobe) ? dataBit :
         (slotStrobe ? 1'b1 : slot_reg);
      irq_next = (ne_next && near_empty_irq_enable) ||
         (ur_next && underrun_irq_enable) ||
         (ms_next && message_sent_irq_enable);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= TDL_IDLE;
         sh_reg <= TDL_FLAG;
         bc_reg <= 4'd0;
         ones_reg <= 3'd0;
         fl_reg <= 2'd0;
         crc_reg <= TDL_CRC_INIT;
         eom_reg <= 1'b0;
         ur_reg <= 1'b0;
         ms_reg <= 1'b0;
         ne_reg <= 1'b0;
         slot_reg <= 1'b1;
         irq_reg <= 1'b0;
         emp_reg <= 1'b1;
         full_reg <= 1'b0;
         active_reg <= 1'b0;
         linkOn_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         bc_reg <= bc_next;
         ones_reg <= ones_next;
         fl_reg <= fl_next;
         crc_reg <= crc_next;
         eom_reg <= eom_next;
         ur_reg <= ur_next;
         ms_reg <= ms_next;
         ne_reg <= ne_next;
         slot_reg <= slot_next;
         irq_reg <= irq_next;
         emp_reg <= !fifoOutValid;
         full_reg <= !fifoInReady;
         active_reg <= active;
         linkOn_reg <= linkOn;
      end
   end
   assign slotBit = slot_reg;
   assign near_empty_flag = ne_reg;
   assign fifo_empty_flag = emp_reg;
   assign underrun_flag = ur_reg;
   assign message_sent_flag = ms_reg;
   assign fifo_full_flag = full_reg;
   assign linkIrq = irq_reg;

   a_ur_block: assert property (@(posedge clk) disable iff (rst)
      ur_reg && msgWrite |-> !acceptWr)
      else $error("write accepted during underrun");
   a_disabled_ones: assert property (@(posedge clk) disable iff (rst)
      !active && slotStrobe |=> slotBit)
      else $error("disabled link bit not one");
   a_ur_abort: assert property (@(posedge clk) disable iff (rst)
      urEvent |=> st_reg == TDL_ABORT && ur_reg)
      else $error("underrun not followed by abort");
   a_ms_set: assert property (@(posedge clk) disable iff (rst)
      msEvent |=> ms_reg)
      else $error("message sent not flagged");
   a_stuff_zero: assert property (@(posedge clk) disable iff (rst)
      stuff && slotStrobe && active |=> !slotBit)
      else $error("no zero after five ones");
   a_ne_level: assert property (@(posedge clk) disable iff (rst)
      count <= (CW+1)'(near_empty_threshold) |=> ne_reg)
      else $error("near empty not set");
   a_full_flag: assert property (@(posedge clk) disable iff (rst)
      count == (CW+1)'(DEPTH) |=> fifo_full_flag)
      else $error("full not shown");
   a_flush_empty: assert property (@(posedge clk) disable iff (rst)
      flush |=> ##1 fifo_empty_flag)
      else $error("flush did not empty");
endmodule : tdl_tx_link

// >>> tx_data_link_hdlc_fifo_bench.sv
// Self-checking bench for the transmit data link
`timescale 1ns/1ps
module tx_data_link_hdlc_fifo_bench;
   import tdl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic msgWrite = 1'b0;
   logic msgEndAddr = 1'b0;
   logic [7:0] mByte = 8'h00;
   logic statusRead = 1'b0;
   logic chEn = 1'b0;
   logic [1:0] fmt = 2'h0;
   logic [2:0] mode = 3'h0;
   logic fcsEn = 1'b0;
   logic neIe = 1'b0;
   logic urIe = 1'b0;
   logic msIe = 1'b0;
   logic [6:0] thr = 7'h00;
   logic [3:0] gap = 4'h3;
   logic slotStrobe, slotBit, ne, emp, ur, ms, full, irq;
   logic [7:0] expq[$];
   int frames, flags, aborts, zeros, n, rxBase;
   int err_total = 0;
   int cmp_count = 0;
   always #2.5 clk = ~clk;
   tdl_tx_link tdl_tx_link_inst (.clk(clk), .rst(rst), .msgWrite(msgWrite),
      .msgEndAddr(msgEndAddr), .message_byte_port(mByte),
      .statusRead(statusRead), .channelEnable(chEn), .frameFormat(fmt),
      .link_mode_select(mode), .check_sequence_enable(fcsEn),
      .near_empty_irq_enable(neIe), .underrun_irq_enable(urIe),
      .message_sent_irq_enable(msIe), .near_empty_threshold(thr),
      .slotStrobe(slotStrobe), .slotBit(slotBit), .near_empty_flag(ne),
      .fifo_empty_flag(emp), .underrun_flag(ur), .message_sent_flag(ms),
      .fifo_full_flag(full), .linkIrq(irq));
   tdl_slot_mdl tdl_slot_mdl_inst (.clk(clk), .rst(rst), .gap(gap),
      .slotStrobe(slotStrobe), .slotBit(slotBit), .frames(frames),
      .flags(flags), .aborts(aborts), .zeros(zeros));
   task automatic chk1(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) err_total++;
      if (g !== e) $display("ERROR %s expected %b seen %b", nm, e, g);
   endtask : chk1
   task automatic chk8(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      cmp_count++;
      if (g !== e) err_total++;
      if (g !== e) $display("ERROR %s expected %h seen %h", nm, e, g);
   endtask : chk8
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [7:0] b, input logic end_of_message_marker);
      @(posedge clk);
      msgWrite <= 1'b1;
      msgEndAddr <= end_of_message_marker;
      mByte <= b;
      @(posedge clk);
      msgWrite <= 1'b0;
   endtask : wr
   task automatic rdStat;
      @(posedge clk);
      statusRead <= 1'b1;
      @(posedge clk);
      statusRead <= 1'b0;
   endtask : rdStat
   function automatic logic [15:0] crcUpd(input logic [15:0] c,
      input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ b[i]) ? ((c >> 1) ^ TDL_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crcUpd
   // First byte all ones forces stuffing early
   task automatic sendMsg(input int len);
      logic [15:0] c;
      logic [7:0] b;
      c = TDL_CRC_INIT;
      for (int i = 0; i < len; i++) begin
         b = (i == 0) ? 8'hff : 8'($urandom);
         c = crcUpd(c, b);
         expq.push_back(b);
         wr(b, i == len - 1);
      end
      if (fcsEn) expq.push_back(~c[7:0]);
      if (fcsEn) expq.push_back(~c[15:8]);
   endtask : sendMsg
   task automatic rxCheck(input int f);
      logic [7:0] got;
      for (int i = 0; i < 20000 && frames < f; i++) @(posedge clk);
      chk1("rx count", 1'b1,
         tdl_slot_mdl_inst.rxq.size() == rxBase + expq.size());
      foreach (expq[i]) begin
         got = tdl_slot_mdl_inst.rxq[rxBase + i];
         chk8("rx byte", expq[i], got);
      end
      rxBase += expq.size();
      expq = {};
   endtask : rxCheck
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   initial begin : watchdog
      repeat (60000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
   initial begin : main
      void'($urandom(32'h50a8379f));
      tick(6);
      rst <= 1'b0;
      tick(2);
      chk8("reset", 8'he0, {slotBit, emp, ne, ur, ms, full, irq, 1'b0});
      $display("test reset done");
      chEn <= 1'b1;
      for (int f = 0; f < 3; f++) begin
         fmt <= 2'(f);
         mode <= 3'(1 << ((f + 1) % 3));
         tick(50);
         n = zeros;
         tick(100);
         chk1("ones off", 1'b1, zeros == n);
         n = flags;
         mode <= 3'(1 << f);
         tick(200);
         chk1("idle flags", 1'b1, flags >= n + 2);
      end
      $display("test formats done");
      for (int r = 0; r < 6; r++) begin
         gap <= 4'($urandom_range(0, 5));
         fcsEn <= r[0];
         msIe <= r[1];
         rdStat();
         n = frames;
         sendMsg($urandom_range(1, 9));
         sendMsg($urandom_range(1, 9));
         rxCheck(n + 2);
         tick(120);
         chk1("sent", 1'b1, ms);
         chk1("irq sent", r[1], irq);
         rdStat();
         tick(3);
         chk1("sent clear", 1'b0, ms);
         chk1("irq clear", 1'b0, irq);
      end
      $display("test messages done");
      urIe <= 1'b1;
      n = aborts;
      wr(8'h5a, 1'b0);
      wr(8'ha5, 1'b0);
      for (int i = 0; i < 3000 && ur !== 1'b1; i++) @(posedge clk);
      chk1("underrun", 1'b1, ur);
      chk1("irq underrun", 1'b1, irq);
      wr(8'h11, 1'b1);
      tick(300);
      chk1("write refused", 1'b1, emp);
      chk1("abort", 1'b1, aborts > n);
      rdStat();
      tick(3);
      chk1("underrun clear", 1'b0, ur);
      n = frames;
      sendMsg(4);
      rxCheck(n + 1);
      $display("test underrun done");
      urIe <= 1'b0;
      msIe <= 1'b0;
      tick(2);
      mode <= 3'h0;
      thr <= 7'($urandom_range(1, TDL_THR_MAX));
      tick(4);
      chk1("empty off", 1'b1, emp);
      for (int i = 1; i <= TDL_FIFO_DEPTH + 1; i++) begin
         wr(8'(i), 1'b0);
         tick(3);
         chk1("near empty", i <= thr, ne);
         chk1("full", i >= TDL_FIFO_DEPTH, full);
      end
      chEn <= 1'b0;
      tick(4);
      chk1("kept full", 1'b1, full);
      neIe <= 1'b1;
      mode <= 3'h7;
      tick(4);
      chEn <= 1'b1;
      tick(4);
      chk1("flushed", 1'b1, emp);
      chk1("not full", 1'b0, full);
      chk1("irq near", 1'b1, irq);
      $display("test levels done");
      tally_and_finish();
   end
endmodule : tx_data_link_hdlc_fifo_bench
